/* plbi_consts.svh */
`ifndef PLBI_CONSTS_SVH
`define PLBI_CONSTS_SVH

// byte cycle lengths in bus clocks
`define BYTE_FAST_CYC 4'h5
`define BYTE_SLOW_CYC 4'h9
// boot alias watchdog, bus clocks after transfer start
`define BOOT_WAIT_CYC 6'h20

// address windows
`define RAM_BASE 32'hFFFC0000
`define RAM_MASK 32'hFFFF0000
`define ROM_BASE 32'hFFA00000
`define ROM_MASK 32'hFFFE0000
`define ALIAS_BASE 32'h00000000
`define ALIAS_MASK 32'hFFFE0000
`define SCSI_BASE 32'hFFF47000
`define SCSI_MASK 32'hFFFFF000
`define MEMC_BASE 32'hFFF43000
`define MEMC_MASK 32'hFFFFFF00
`define PORT_BASE 32'hFFF46000
`define PORT_MASK 32'hFFFFFFFC
`define ATTN_BASE 32'hFFF46004
`define ATTN_MASK 32'hFFFFFFFC

// lan master attributes
`define LAN_TT 2'h0
`define LAN_TM 3'h5

// register indices
`define REG_GEN_CTRL 4'h0
`define REG_LAN_ICR 4'h1
`define REG_LANERR_ICR 4'h2
`define REG_SCSI_ICR 4'h3
`define REG_MASK_LVL 4'h4
`define REG_VEC_BASE 4'h5

// general control fields
`define GC_RAM_FAST 0
`define GC_ROM_FAST 1
`define GC_ALIAS 2
`define GC_DIRECT 3
// interrupt control fields
`define ICR_EN 3
`define ICR_STAT 7
// vector codes
`define VEC_LAN 3'h1
`define VEC_LANERR 3'h2
`define VEC_SCSI 3'h3

`endif

/* plbi_pkg.sv */
package plbi_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic read;
        logic [1:0] size;
    } lb_req_t;

    typedef struct packed {
        logic [1:0] snoop;
        logic en;
        logic [2:0] level;
    } irq_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SIZE = 2'b01,
        ST_WATCH = 2'b10
    } bus_state_t;

endpackage

/* byte_sizer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "plbi_consts.svh"

module byte_sizer
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // request
    input wire logic i_start,
    input wire plbi_pkg::lb_req_t i_req,
    input wire logic i_slow,
    // byte device
    output logic o_strobe,
    output logic [1:0] o_lane,
    output logic [7:0] o_wbyte,
    input wire logic [7:0] i_rbyte,
    // completion
    output logic o_done,
    output logic [31:0] o_rdata
);

logic busy_q;
logic [1:0] lane_q;
logic [1:0] left_q;
logic [3:0] cyc_q;
logic [3:0] limit_q;
logic [31:0] wdata_q;
logic [7:0] wbyte_q;
logic done_q;
logic [31:0] rdata_q;

// long words and lines start at lane 0; a line is cut to one long word
wire logic multi = (i_req.size == 2'h0) || (i_req.size == 2'h3);
wire logic [1:0] first_lane = multi ? 2'h0 : i_req.addr[1:0];
wire logic [1:0] count_m1 = multi ? 2'h3 : ((i_req.size == 2'h2) ? 2'h1 : 2'h0);
wire logic last_cyc = (cyc_q == limit_q - 4'h1);
wire logic [1:0] next_lane = lane_q + 2'h1;

function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] l);
    pick = w[8'(31 - 8 * l) -: 8];
endfunction

always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        busy_q <= 1'b0;
        lane_q <= 2'h0;
        left_q <= 2'h0;
        cyc_q <= 4'h0;
        limit_q <= `BYTE_FAST_CYC;
        wdata_q <= 32'h00000000;
        wbyte_q <= 8'h00;
        done_q <= 1'b0;
        rdata_q <= 32'h00000000;
    end
    else
    begin
        done_q <= 1'b0;
        if (i_start && !busy_q)
        begin
            busy_q <= 1'b1;
            lane_q <= first_lane;
            left_q <= count_m1;
            cyc_q <= 4'h0;
            limit_q <= i_slow ? `BYTE_SLOW_CYC : `BYTE_FAST_CYC;
            wdata_q <= i_req.wdata;
            wbyte_q <= pick(i_req.wdata, first_lane);
            rdata_q <= 32'h00000000;
        end
        else if (busy_q)
        begin
            cyc_q <= cyc_q + 4'h1;
            if (last_cyc)
            begin
                rdata_q[8'(31 - 8 * lane_q) -: 8] <= i_rbyte;
                cyc_q <= 4'h0;
                if (left_q == 2'h0)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                begin
                    lane_q <= next_lane;
                    left_q <= left_q - 2'h1;
                    wbyte_q <= pick(wdata_q, next_lane);
                end
            end
        end
    end
end

assign o_strobe = busy_q;
assign o_lane = lane_q;
assign o_wbyte = wbyte_q;
assign o_done = done_q;
assign o_rdata = rdata_q;

endmodule
`default_nettype wire

/* periph_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "plbi_consts.svh"

module periph_bus_if
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // local bus slave
    input wire logic i_transfer_start_n,
    input wire plbi_pkg::lb_req_t i_lb_req,
    input wire logic i_transfer_ack_n,
    input wire logic i_transfer_error_ack_n,
    output logic o_transfer_ack_n,
    output logic o_transfer_ack_oe,
    output logic [31:0] o_lb_rdata,
    output logic o_lb_rdata_oe,
    // byte wide devices
    output logic o_battery_backed_ram_cs,
    output logic o_download_rom_cs,
    output logic [16:0] o_byte_addr,
    output logic o_byte_write,
    output logic [7:0] o_byte_wdata,
    input wire logic [7:0] i_byte_rdata,
    // peripheral selects
    output logic o_scsi_sel,
    output logic o_memc_sel,
    output logic o_lan_port_write,
    output logic o_lan_port_lower,
    output logic o_lan_chan_attn,
    // lan coprocessor as bus master
    input wire logic i_lan_owns_bus,
    input wire logic i_lan_int,
    input wire logic i_lan_port_reset,
    input wire logic i_lan_error_policy_pin,
    input wire logic i_lan_error_policy_oe,
    output logic [1:0] o_snoop_control,
    output logic [1:0] o_transfer_type,
    output logic [2:0] o_transfer_modifier,
    output logic o_lan_attr_oe,
    output logic o_lan_holdoff_n,
    // interrupts
    input wire logic i_scsi_irq_n,
    input wire logic [2:0] i_encoded_level_n,
    output logic [2:0] o_encoded_level_outputs_n,
    output logic o_encoded_level_oe,
    output logic o_int,
    input wire logic i_iack,
    input wire logic [2:0] i_iack_level,
    output logic [7:0] o_iack_vector,
    output logic o_iack_valid,
    // register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata
);

function automatic logic hit(input logic [31:0] a, input logic [31:0] base, input logic [31:0] mask);
    hit = ((a & mask) == base);
endfunction

function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
    max3 = (a > b) ? a : b;
endfunction

////////////////////////////////////////////////////////////////////////////////

plbi_pkg::bus_state_t state_q;
plbi_pkg::lb_req_t req_q;
logic [3:0] gen_ctrl_q;
plbi_pkg::irq_ctl_t lan_icr_q;
plbi_pkg::irq_ctl_t err_icr_q;
plbi_pkg::irq_ctl_t scsi_icr_q;
logic err_stat_q;
logic [2:0] mask_q;
logic [7:0] vec_base_q;
logic boot_pend_q;
logic [5:0] watch_q;
logic rom_sel_q;
logic ta_n_q;
logic ta_oe_q;
logic [31:0] rdata_q;
logic rdata_oe_q;
logic scsi_sel_q;
logic memc_sel_q;
logic port_wr_q;
logic port_lo_q;
logic attn_q;
logic holdoff_q;
logic [1:0] snoop_q;
logic attr_oe_q;
logic [2:0] enc_n_q;
logic enc_oe_q;
logic int_q;
logic [7:0] vec_q;
logic vec_valid_q;
logic [31:0] reg_rdata_q;

wire logic alias_on = gen_ctrl_q[`GC_ALIAS];
wire logic direct = gen_ctrl_q[`GC_DIRECT];

////////////////////////////////////////////////////////////////////////////////
// address decode of a new transfer

wire logic ts = !i_transfer_start_n;
wire logic [31:0] a = i_lb_req.addr;
wire logic hit_ram = hit(a, `RAM_BASE, `RAM_MASK);
wire logic hit_rom = hit(a, `ROM_BASE, `ROM_MASK) || (alias_on && hit(a, `ALIAS_BASE, `ALIAS_MASK));
wire logic hit_port = hit(a, `PORT_BASE, `PORT_MASK) && !i_lb_req.read;
wire logic hit_attn = hit(a, `ATTN_BASE, `ATTN_MASK);
wire logic hit_scsi = hit(a, `SCSI_BASE, `SCSI_MASK);
wire logic hit_memc = hit(a, `MEMC_BASE, `MEMC_MASK);
wire logic hit_mem = hit_ram || hit_rom;
wire logic idle_ts = (state_q == plbi_pkg::ST_IDLE) && ts && !i_lan_owns_bus;
wire logic bus_answer = !i_transfer_ack_n || !i_transfer_error_ack_n;
wire logic rescue = (state_q == plbi_pkg::ST_WATCH) && !bus_answer
                    && (watch_q == `BOOT_WAIT_CYC - 6'h1);

////////////////////////////////////////////////////////////////////////////////
// byte sizing engine

wire logic sz_start = (idle_ts && hit_mem) || rescue;
wire plbi_pkg::lb_req_t sz_req = rescue ? req_q : i_lb_req;
wire logic sz_rom = rescue || (hit_rom && !hit_ram);
wire logic sz_slow = sz_rom ? !gen_ctrl_q[`GC_ROM_FAST] : !gen_ctrl_q[`GC_RAM_FAST];
logic sz_strobe;
logic [1:0] sz_lane;
logic [7:0] sz_wbyte;
logic sz_done;
logic [31:0] sz_rdata;

byte_sizer u_sizer
(
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(sz_start),
    .i_req(sz_req),
    .i_slow(sz_slow),
    .o_strobe(sz_strobe),
    .o_lane(sz_lane),
    .o_wbyte(sz_wbyte),
    .i_rbyte(i_byte_rdata),
    .o_done(sz_done),
    .o_rdata(sz_rdata)
);

assign o_battery_backed_ram_cs = sz_strobe && !rom_sel_q;
assign o_download_rom_cs = sz_strobe && rom_sel_q;
assign o_byte_addr = {req_q.addr[16:2], sz_lane};
assign o_byte_write = sz_strobe && !req_q.read;
assign o_byte_wdata = sz_wbyte;

////////////////////////////////////////////////////////////////////////////////
// lan coprocessor bus error handling

wire logic lan_err = i_lan_owns_bus && !i_transfer_error_ack_n && i_transfer_ack_n;
// policy pin counts as low only when actively driven low
wire logic policy_low = i_lan_error_policy_oe && !i_lan_error_policy_pin;
wire logic lan_ta = lan_err && policy_low;

////////////////////////////////////////////////////////////////////////////////
// transfer sequencing

always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        state_q <= plbi_pkg::ST_IDLE;
        req_q <= '0;
        rom_sel_q <= 1'b0;
        boot_pend_q <= 1'b1;
        watch_q <= 6'h00;
    end
    else
    begin
        watch_q <= watch_q + 6'h01;
        if (sz_start)
        begin
            rom_sel_q <= sz_rom;
        end
        unique case (state_q)
            plbi_pkg::ST_IDLE:
            begin
                if (idle_ts)
                begin
                    req_q <= i_lb_req;
                    boot_pend_q <= 1'b0;
                    watch_q <= 6'h00;
                    if (hit_mem)
                    begin
                        state_q <= plbi_pkg::ST_SIZE;
                    end
                    else if (boot_pend_q)
                    begin
                        state_q <= plbi_pkg::ST_WATCH;
                    end
                end
            end
            plbi_pkg::ST_SIZE:
            begin
                if (sz_done)
                begin
                    state_q <= plbi_pkg::ST_IDLE;
                end
            end
            plbi_pkg::ST_WATCH:
            begin
                if (bus_answer)
                begin
                    state_q <= plbi_pkg::ST_IDLE;
                end
                else if (rescue)
                begin
                    state_q <= plbi_pkg::ST_SIZE;
                end
            end
            default:
            begin
                state_q <= plbi_pkg::ST_IDLE;
            end
        endcase
    end
end

// acknowledge and read data, one cycle each
wire logic ack_now = sz_done || lan_ta || (idle_ts && (hit_port || hit_attn));
always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        ta_n_q <= 1'b1;
        ta_oe_q <= 1'b0;
        rdata_q <= 32'h00000000;
        rdata_oe_q <= 1'b0;
    end
    else
    begin
        ta_n_q <= !ack_now;
        ta_oe_q <= ack_now;
        rdata_q <= sz_done ? sz_rdata : 32'h00000000;
        rdata_oe_q <= sz_done && req_q.read;
    end
end

////////////////////////////////////////////////////////////////////////////////
// selects, port and attention strobes, lan master attributes

always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        scsi_sel_q <= 1'b0;
        memc_sel_q <= 1'b0;
        port_wr_q <= 1'b0;
        port_lo_q <= 1'b0;
        attn_q <= 1'b0;
        holdoff_q <= 1'b0;
        snoop_q <= 2'h0;
        attr_oe_q <= 1'b0;
    end
    else
    begin
        // selects stand from transfer start until the cycle is answered
        scsi_sel_q <= (scsi_sel_q && !bus_answer) || (idle_ts && hit_scsi);
        memc_sel_q <= (memc_sel_q && !bus_answer) || (idle_ts && hit_memc);
        port_wr_q <= idle_ts && hit_port;
        port_lo_q <= idle_ts && hit_port && a[1];
        attn_q <= idle_ts && hit_attn;
        // a new error wins over a port reset in the same cycle
        holdoff_q <= (lan_err && !policy_low) || (holdoff_q && !i_lan_port_reset);
        snoop_q <= lan_icr_q.snoop;
        attr_oe_q <= i_lan_owns_bus;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt routing

wire logic lan_req = i_lan_int && lan_icr_q.en;
wire logic scsi_req = !i_scsi_irq_n && scsi_icr_q.en;
wire logic err_req = err_stat_q && err_icr_q.en;
wire logic [2:0] lvl_lan = lan_req ? lan_icr_q.level : 3'h0;
wire logic [2:0] lvl_err = err_req ? err_icr_q.level : 3'h0;
wire logic [2:0] lvl_scsi = scsi_req ? scsi_icr_q.level : 3'h0;
wire logic [2:0] lvl_int = max3(max3(lvl_lan, lvl_err), lvl_scsi);
wire logic [2:0] lvl_all = max3(lvl_int, ~i_encoded_level_n);
// vector follows the highest pending source at the acknowledged level
wire logic [2:0] iack_code = (lan_req && lan_icr_q.level == i_iack_level) ? `VEC_LAN :
                             (err_req && err_icr_q.level == i_iack_level) ? `VEC_LANERR :
                             `VEC_SCSI;

always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        enc_n_q <= 3'h7;
        enc_oe_q <= 1'b0;
        int_q <= 1'b0;
        vec_q <= 8'h00;
        vec_valid_q <= 1'b0;
    end
    else
    begin
        enc_n_q <= direct ? ~lvl_int : 3'h7;
        enc_oe_q <= direct;
        int_q <= !direct && (lvl_all > mask_q);
        vec_q <= i_iack ? {vec_base_q[7:3], iack_code} : 8'h00;
        vec_valid_q <= i_iack;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register port

wire logic wr_gc = i_reg_wr && (i_reg_addr == `REG_GEN_CTRL);
wire logic wr_err = i_reg_wr && (i_reg_addr == `REG_LANERR_ICR);
// software write of zero clears the alias; the hardware set wins
wire logic alias_d = rescue || (wr_gc ? i_reg_wdata[`GC_ALIAS] : alias_on);
wire logic err_clr = wr_err && i_reg_wdata[`ICR_STAT];

always_ff @(posedge i_ref_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        gen_ctrl_q <= 4'h0;
        lan_icr_q <= '0;
        err_icr_q <= '0;
        scsi_icr_q <= '0;
        err_stat_q <= 1'b0;
        mask_q <= 3'h0;
        vec_base_q <= 8'h00;
        reg_rdata_q <= 32'h00000000;
    end
    else
    begin
        gen_ctrl_q[`GC_ALIAS] <= alias_d;
        if (wr_gc)
        begin
            gen_ctrl_q[`GC_RAM_FAST] <= i_reg_wdata[`GC_RAM_FAST];
            gen_ctrl_q[`GC_ROM_FAST] <= i_reg_wdata[`GC_ROM_FAST];
            gen_ctrl_q[`GC_DIRECT] <= i_reg_wdata[`GC_DIRECT];
        end
        if (i_reg_wr && i_reg_addr == `REG_LAN_ICR)
        begin
            lan_icr_q <= i_reg_wdata[5:0];
        end
        if (wr_err)
        begin
            err_icr_q <= {2'h0, i_reg_wdata[3:0]};
        end
        if (i_reg_wr && i_reg_addr == `REG_SCSI_ICR)
        begin
            scsi_icr_q <= {2'h0, i_reg_wdata[3:0]};
        end
        if (i_reg_wr && i_reg_addr == `REG_MASK_LVL)
        begin
            mask_q <= i_reg_wdata[2:0];
        end
        if (i_reg_wr && i_reg_addr == `REG_VEC_BASE)
        begin
            vec_base_q <= i_reg_wdata[7:0];
        end
        err_stat_q <= lan_err || (err_stat_q && !err_clr);
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                `REG_GEN_CTRL: reg_rdata_q <= {28'h0000000, gen_ctrl_q};
                `REG_LAN_ICR: reg_rdata_q <= {24'h000000, lan_req, 1'b0, lan_icr_q};
                `REG_LANERR_ICR: reg_rdata_q <= {24'h000000, err_stat_q, 1'b0, err_icr_q};
                `REG_SCSI_ICR: reg_rdata_q <= {24'h000000, scsi_req, 1'b0, scsi_icr_q};
                `REG_MASK_LVL: reg_rdata_q <= {29'h00000000, mask_q};
                `REG_VEC_BASE: reg_rdata_q <= {24'h000000, vec_base_q};
                default: reg_rdata_q <= 32'h00000000;
            endcase
        end
        else
        begin
            reg_rdata_q <= 32'h00000000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign o_transfer_ack_n = ta_n_q;
assign o_transfer_ack_oe = ta_oe_q;
assign o_lb_rdata = rdata_q;
assign o_lb_rdata_oe = rdata_oe_q;
assign o_scsi_sel = scsi_sel_q;
assign o_memc_sel = memc_sel_q;
assign o_lan_port_write = port_wr_q;
assign o_lan_port_lower = port_lo_q;
assign o_lan_chan_attn = attn_q;
assign o_snoop_control = snoop_q;
assign o_transfer_type = `LAN_TT;
assign o_transfer_modifier = `LAN_TM;
assign o_lan_attr_oe = attr_oe_q;
assign o_lan_holdoff_n = !holdoff_q;
assign o_encoded_level_outputs_n = enc_n_q;
assign o_encoded_level_oe = enc_oe_q;
assign o_int = int_q;
assign o_iack_vector = vec_q;
assign o_iack_valid = vec_valid_q;
assign o_reg_rdata = reg_rdata_q;

endmodule
`default_nettype wire

/* byte_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module byte_mem_model
(
    // clock
    input wire logic i_ref_clk,
    // byte device
    input wire logic i_cs,
    input wire logic [16:0] i_addr,
    input wire logic i_write,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
logic [7:0] mem_q [256];
logic [7:0] last_q = 8'h00;

initial
begin
    for (int i = 0; i < 256; i++)
        mem_q[i] = 8'h11 + 8'(i);
end

always @(posedge i_ref_clk)
begin
    if (i_cs && i_write)
        mem_q[i_addr[7:0]] <= i_wdata;
    if (i_cs)
        last_q <= o_rdata;
end

// deselected: inverse of last byte, so a stale sample never matches
assign o_rdata = i_cs ? mem_q[i_addr[7:0]] : ~last_q;

endmodule
`default_nettype wire

/* plbi_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "plbi_consts.svh"

module plbi_chk
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // watched ports
    input wire plbi_pkg::lb_req_t i_lb_req,
    input wire logic i_transfer_ack_n,
    input wire logic i_transfer_error_ack_n,
    input wire logic i_lan_owns_bus,
    input wire logic i_lan_error_policy_pin,
    input wire logic i_lan_error_policy_oe,
    input wire logic o_transfer_ack_n,
    input wire logic o_battery_backed_ram_cs,
    input wire logic [16:0] o_byte_addr,
    input wire logic o_scsi_sel,
    input wire logic o_memc_sel,
    input wire logic o_lan_port_write,
    input wire logic o_lan_chan_attn,
    input wire logic [1:0] o_transfer_type,
    input wire logic [2:0] o_transfer_modifier,
    input wire logic o_lan_attr_oe,
    input wire logic o_lan_holdoff_n
);
default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (i_rst);

wire lan_err = i_lan_owns_bus && !i_transfer_error_ack_n && i_transfer_ack_n;
wire ack_policy = i_lan_error_policy_oe && !i_lan_error_policy_pin;

////////////////////////////////////////
lan_attr_a: assert property (i_lan_owns_bus |=> o_lan_attr_oe && o_transfer_type == `LAN_TT
    && o_transfer_modifier == `LAN_TM) else $error("lan attributes wrong");
chan_attn_a: assert property (o_lan_chan_attn |-> ($past(i_lb_req.addr) & `ATTN_MASK) == `ATTN_BASE)
    else $error("attention at wrong address");
port_write_a: assert property (o_lan_port_write |-> !$past(i_lb_req.read)
    && ($past(i_lb_req.addr) & `PORT_MASK) == `PORT_BASE) else $error("port decode wrong");
scsi_win_a: assert property ($rose(o_scsi_sel) |-> ($past(i_lb_req.addr) & `SCSI_MASK) == `SCSI_BASE)
    else $error("scsi select outside window");
memc_win_a: assert property ($rose(o_memc_sel) |-> ($past(i_lb_req.addr) & `MEMC_MASK) == `MEMC_BASE)
    else $error("memc select outside window");
holdoff_cause_a: assert property ($fell(o_lan_holdoff_n) |-> $past(lan_err && !ack_policy))
    else $error("holdoff without bus error");
err_ack_a: assert property (lan_err && ack_policy |=> !o_transfer_ack_n && o_lan_holdoff_n)
    else $error("bus error not ended by ack");
byte_len_a: assert property ($rose(o_battery_backed_ram_cs) |-> o_battery_backed_ram_cs[*5])
    else $error("byte cycle too short");
lane_order_a: assert property (o_battery_backed_ram_cs && $past(o_battery_backed_ram_cs)
    && o_byte_addr[1:0] != $past(o_byte_addr[1:0]) |-> o_byte_addr[1:0] == $past(o_byte_addr[1:0]) + 2'h1)
    else $error("byte lanes out of order");

cover property (o_lan_chan_attn);
cover property ($fell(o_lan_holdoff_n));
cover property ($rose(o_battery_backed_ram_cs));

endmodule
`default_nettype wire

/* peripheral_local_bus_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none

module peripheral_local_bus_interface_test;
typedef struct {logic [31:0] a; logic rd; logic [1:0] sz; logic [31:0] wd, ex, mk; int lat; logic [3:0] gc;} row_t;
logic i_ref_clk = 1'b0, i_rst = 1'b1, i_transfer_start_n = 1'b1, i_transfer_ack_n = 1'b1;
logic i_transfer_error_ack_n = 1'b1, i_lan_owns_bus = 1'b0, i_lan_int = 1'b0, i_lan_port_reset = 1'b0;
logic i_lan_error_policy_pin = 1'b0, i_lan_error_policy_oe = 1'b0, i_scsi_irq_n = 1'b1, i_iack = 1'b0;
logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
logic [2:0] i_encoded_level_n = 3'h7, i_iack_level = 3'h0, o_transfer_modifier, o_encoded_level_outputs_n;
logic [3:0] i_reg_addr = 4'h0;
logic [31:0] i_reg_wdata = 32'h0, o_lb_rdata, o_reg_rdata;
plbi_pkg::lb_req_t i_lb_req = '0;
logic [7:0] i_byte_rdata, o_byte_wdata, o_iack_vector;
logic [16:0] o_byte_addr;
logic [1:0] o_snoop_control, o_transfer_type;
logic o_transfer_ack_n, o_transfer_ack_oe, o_lb_rdata_oe, o_battery_backed_ram_cs, o_download_rom_cs, o_byte_write;
logic o_scsi_sel, o_memc_sel, o_lan_port_write, o_lan_port_lower, o_lan_chan_attn, o_lan_attr_oe, o_lan_holdoff_n;
logic o_encoded_level_oe, o_int, o_iack_valid;
int mismatches = 0, check_count = 0, n;
row_t rows [13] = '{
    '{32'h00000008, 1'b1, 2'h1, 32'h0, 32'h19000000, 32'hFF000000, 7, 4'h7},
    '{32'hFFFC0004, 1'b0, 2'h0, 32'hCAFEF00D, 32'h0, 32'h0, 22, 4'h3},
    '{32'hFFFC0004, 1'b1, 2'h0, 32'h0, 32'hCAFEF00D, 32'hFFFFFFFF, 22, 4'h3},
    '{32'hFFFC0006, 1'b1, 2'h2, 32'h0, 32'h0000F00D, 32'h0000FFFF, 12, 4'h3},
    '{32'hFFA00009, 1'b1, 2'h1, 32'h0, 32'h001A0000, 32'h00FF0000, 7, 4'h3},
    '{32'hFFFC0005, 1'b1, 2'h1, 32'h0, 32'h00FE0000, 32'h00FF0000, 11, 4'h0},
    '{32'hFFA00010, 1'b1, 2'h0, 32'h0, 32'h21222324, 32'hFFFFFFFF, 38, 4'h0},
    '{32'h0000000C, 1'b1, 2'h1, 32'h0, 32'h0, 32'h0, 0, 4'h3},
    '{32'hFFF46000, 1'b0, 2'h2, 32'h12340000, 32'h0, 32'h0, 1, 4'h3},
    '{32'hFFF46002, 1'b0, 2'h2, 32'h00005678, 32'h0, 32'h0, 1, 4'h3},
    '{32'hFFF46000, 1'b1, 2'h2, 32'h0, 32'h0, 32'h0, 0, 4'h3},
    '{32'hFFF46004, 1'b1, 2'h0, 32'h0, 32'h0, 32'h0, 1, 4'h3},
    '{32'hFFF46004, 1'b0, 2'h0, 32'h0, 32'h0, 32'h0, 1, 4'h3}};

periph_bus_if u_periph_bus_if (.*);
byte_mem_model u_byte_mem_model (.i_ref_clk, .i_cs(o_battery_backed_ram_cs | o_download_rom_cs),
    .i_addr(o_byte_addr), .i_write(o_byte_write), .i_wdata(o_byte_wdata), .o_rdata(i_byte_rdata));

always #5 i_ref_clk = ~i_ref_clk;

////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
        mismatches++;
        $display("BAD %s expected %h seen %h", nm, e, s);
    end
endtask

task automatic complete_run();
    if (mismatches == 0 && check_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

task automatic timeout();
    mismatches++;
    complete_run();
endtask

task automatic settle();
    repeat (3) @(posedge i_ref_clk);
    #1;
endtask

task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
endtask

task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(nm, o_reg_rdata, e);
endtask

// request held until the ack so the decode sees a stable address
task automatic bus(input logic [31:0] a, input logic r, input logic [1:0] s, input logic [31:0] w, input int lim);
    @(posedge i_ref_clk);
    i_lb_req <= '{a, w, r, s};
    i_transfer_start_n <= 1'b0;
    @(posedge i_ref_clk);
    i_transfer_start_n <= 1'b1;
    #1;
    // ack stands one cycle only
    n = 1;
    while (o_transfer_ack_n !== 1'b0 && n < lim)
    begin
        @(posedge i_ref_clk);
        #1;
        n++;
    end
endtask

////////////////////////////////////////
initial
begin
    repeat (5) @(posedge i_ref_clk);
    #1;
    chk("reset outs", {o_transfer_ack_n, o_lan_holdoff_n, o_encoded_level_outputs_n, o_int}, 6'h3E);
    i_rst <= 1'b0;
    rd(4'h0, 32'h0, "alias at reset");
    bus(32'h00000000, 1'b1, 2'h0, 32'h0, 100);
    if (n == 100)
        timeout();
    chk("boot data", o_lb_rdata, 32'h11121314);
    chk("boot wait", n > 32, 1'b1);
    rd(4'h0, 32'h4, "alias set");
    foreach (rows[i])
    begin
        wr(4'h0, 32'(rows[i].gc));
        bus(rows[i].a, rows[i].rd, rows[i].sz, rows[i].wd, rows[i].lat == 0 ? 12 : rows[i].lat + 4);
        if (rows[i].lat != 0 && n == rows[i].lat + 4)
            timeout();
        chk("ack delay", n, rows[i].lat == 0 ? 12 : rows[i].lat);
        chk("read data", o_lb_rdata & rows[i].mk, rows[i].ex);
        chk("ack oe", o_transfer_ack_oe, rows[i].lat != 0);
        chk("rdata oe", o_lb_rdata_oe, rows[i].rd && rows[i].mk != 0);
        chk("port write", o_lan_port_write, rows[i].a[31:2] == 30'h3FFD1800 && !rows[i].rd);
        chk("port lower", o_lan_port_lower, rows[i].a == 32'hFFF46002);
        chk("attention", o_lan_chan_attn, rows[i].a == 32'hFFF46004);
    end
    for (int k = 0; k < 3; k++)
    begin
        bus(k == 0 ? 32'hFFF47010 : k == 1 ? 32'hFFF43008 : 32'hFFF44000, 1'b1, 2'h0, 32'h0, 3);
        chk("scsi sel", o_scsi_sel, k == 0);
        chk("memc sel", o_memc_sel, k == 1);
        @(posedge i_ref_clk);
        i_transfer_ack_n <= 1'b0;
        @(posedge i_ref_clk);
        i_transfer_ack_n <= 1'b1;
        settle();
        chk("sel release", o_scsi_sel | o_memc_sel, 1'b0);
    end
    wr(4'h1, 32'h20);
    i_lan_owns_bus <= 1'b1;
    settle();
    chk("snoop", o_snoop_control, 2'h2);
    chk("attr oe", o_lan_attr_oe, 1'b1);
    chk("type mod", {o_transfer_type, o_transfer_modifier}, 5'h05);
    for (int p = 0; p < 2; p++)
    begin
        @(posedge i_ref_clk);
        i_lan_error_policy_oe <= p == 0;
        i_transfer_error_ack_n <= 1'b0;
        @(posedge i_ref_clk);
        i_transfer_error_ack_n <= 1'b1;
        #1;
        chk("err ack", o_transfer_ack_n, p);
        chk("holdoff", o_lan_holdoff_n, p == 0);
    end
    settle();
    chk("holdoff held", o_lan_holdoff_n, 1'b0);
    i_lan_port_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_lan_port_reset <= 1'b0;
    settle();
    chk("holdoff freed", o_lan_holdoff_n, 1'b1);
    rd(4'h2, 32'h80, "error status");
    i_lan_owns_bus <= 1'b0;
    wr(4'h4, 32'h3);
    wr(4'h1, 32'h0D);
    i_lan_int <= 1'b1;
    settle();
    chk("int above mask", o_int, 1'b1);
    wr(4'h4, 32'h6);
    settle();
    chk("int masked", o_int, 1'b0);
    i_encoded_level_n <= 3'h0;
    settle();
    chk("external level", o_int, 1'b1);
    i_encoded_level_n <= 3'h7;
    wr(4'h4, 32'h0);
    wr(4'h1, 32'h05);
    settle();
    chk("lan disabled", o_int, 1'b0);
    wr(4'h1, 32'h0D);
    wr(4'h3, 32'h0E);
    i_scsi_irq_n <= 1'b0;
    wr(4'h0, 32'h8);
    settle();
    chk("scsi level", o_encoded_level_outputs_n, 3'h1);
    chk("level oe", o_encoded_level_oe, 1'b1);
    i_scsi_irq_n <= 1'b1;
    settle();
    chk("lan level", o_encoded_level_outputs_n, 3'h2);
    wr(4'h5, 32'hA8);
    i_iack <= 1'b1;
    i_iack_level <= 3'h5;
    @(posedge i_ref_clk);
    i_iack <= 1'b0;
    #1;
    chk("lan vector", o_iack_vector, 8'hA9);
    chk("vector valid", o_iack_valid, 1'b1);
    complete_run();
end

endmodule

bind periph_bus_if plbi_chk u_plbi_chk (.*);
`default_nettype wire
